// File: rrc_defines.svh
// register indices, reset values and field positions of the reference rate bank
`ifndef RRC_DEFINES_SVH
`define RRC_DEFINES_SVH

`define RRC_IDX_FREEZE      8'h0D
`define RRC_IDX_STATUS      8'h0E
`define RRC_IDX_CALC        8'h0F
`define RRC_IDX_BASE_HI     8'h10
`define RRC_IDX_BASE_LO     8'h11
`define RRC_IDX_MULT_HI     8'h12
`define RRC_IDX_MULT_LO     8'h13
`define RRC_IDX_RATIO_B3    8'h14
`define RRC_IDX_RATIO_B0    8'h17
`define RRC_IDX_STAGE_FIRST 8'h10
`define RRC_STAGE_BYTES     8

`define RRC_FREEZE_ON       8'h01
`define RRC_FREEZE_OFF      8'h00
`define RRC_FREEZE_RST      8'h00
`define RRC_BASE_RST        16'h9C40
`define RRC_MULT_RST        16'h0F30
`define RRC_RATIO_RST       32'h00010001

`define RRC_NUMER_MSB       31
`define RRC_NUMER_LSB       16
`define RRC_DENOM_MSB       15
`define RRC_DENOM_LSB       0

`define RRC_ADR_IDX_MSB     9
`define RRC_ADR_IDX_LSB     2
`define RRC_DIV_STEPS       6'h30

`endif

// File: rrc_pkg.sv
// types shared by the reference rate bank
package rrc_pkg;
	typedef enum logic [0:0] {
		RRC_DIV_IDLE,
		RRC_DIV_RUN
	} rrc_div_state_type;

	typedef logic [7:0]  rrc_byte_type;
	typedef logic [47:0] rrc_freq_type;
endpackage

// File: rrc_div.sv
// serial divider: expected reference frequency from product and denominator
`include "rrc_defines.svh"
module rrc_div
	import rrc_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         start_i,
	input  wire rrc_freq_type dividend_i,
	input  wire logic [15:0]  divisor_i,
	output logic              busy_o,
	output logic              valid_o,
	output rrc_freq_type      quotient_o
);
	rrc_div_state_type state_r;
	rrc_freq_type      quo_r;
	logic [16:0]       rem_r;
	logic [15:0]       dvs_r;
	logic [5:0]        cnt_r;
	rrc_freq_type      res_r;
	logic              valid_r;

	// one restoring step: shift in next dividend bit, subtract if it fits
	wire logic [16:0] rem_sh  = {rem_r[15:0], quo_r[47]};
	wire logic        fits    = rem_sh >= {1'b0, dvs_r};
	wire logic [16:0] rem_nxt = fits ? (rem_sh - {1'b0, dvs_r}) : rem_sh;
	wire logic        last    = cnt_r == (`RRC_DIV_STEPS - 6'h01);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= RRC_DIV_IDLE;
			quo_r   <= '0;
			rem_r   <= '0;
			dvs_r   <= 16'h0001;
			cnt_r   <= '0;
			res_r   <= '0;
			valid_r <= 1'b0;
		end
		else if (start_i)
		begin
			// a new start abandons any division in progress
			state_r <= RRC_DIV_RUN;
			quo_r   <= dividend_i;
			rem_r   <= '0;
			dvs_r   <= divisor_i;
			cnt_r   <= '0;
			valid_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				RRC_DIV_IDLE:
				begin
					state_r <= RRC_DIV_IDLE;
				end
				RRC_DIV_RUN:
				begin
					rem_r <= rem_nxt;
					quo_r <= {quo_r[46:0], fits};
					cnt_r <= cnt_r + 6'h01;
					if (last)
					begin
						state_r <= RRC_DIV_IDLE;
						res_r   <= {quo_r[46:0], fits};
						valid_r <= 1'b1;
					end
				end
				default:
				begin
					state_r <= RRC_DIV_IDLE;
				end
			endcase
		end
	end

	assign busy_o     = state_r == RRC_DIV_RUN;
	assign valid_o    = valid_r;
	assign quotient_o = res_r;
endmodule

// File: rrc_regs.sv
// wishbone register bank for the primary reference rate configuration
`include "rrc_defines.svh"
// Contract
// - freeze control is one 8-bit register
// - writing 0x01 freezes sticky status updates
// - writing 0x00 resumes sticky status updates
// - base rate is 16-bit hertz value
// - multiplier is 16-bit unsigned rate factor
// - expected frequency equals base*mult*num/den
// - ratio: numerator high half, denominator low
module rrc_regs
	import rrc_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [31:0]  wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic              wb_ack_o,
	output logic [31:0]       wb_dat_o,
	input  wire logic [7:0]   status_event_i,
	output logic              status_freeze_o,
	output logic [7:0]        frozen_read_status_o,
	output logic [15:0]       base_rate_hz_o,
	output logic [15:0]       rate_multiplier_o,
	output logic [15:0]       fec_numerator_o,
	output logic [15:0]       fec_denominator_o,
	output rrc_freq_type      expected_freq_o,
	output logic              expected_valid_o
);
	// true when the bus index addresses the given register
	function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
		idx_is = idx == want;
	endfunction

	logic              ack_r;
	logic [31:0]       rdat_r;
	rrc_byte_type      freeze_r;
	logic              frozen_r;
	logic [7:0]        stat_r;
	logic [7:0]        pend_r;
	rrc_byte_type      stage_r [`RRC_STAGE_BYTES];
	logic [15:0]       base_r;
	logic [15:0]       mult_r;
	logic [31:0]       ratio_r;
	logic              start_r;
	logic              div_busy;
	logic              div_valid;
	rrc_freq_type      div_quot;

	// bus decode
	wire logic [7:0] idx      = wb_adr_i[`RRC_ADR_IDX_MSB:`RRC_ADR_IDX_LSB];
	wire logic       adr_ok   = (wb_adr_i[31:`RRC_ADR_IDX_MSB+1] == '0) && (wb_adr_i[1:0] == 2'h0);
	wire logic       req      = wb_cyc_i && wb_stb_i;
	wire logic       wr       = req && ack_r && wb_we_i && wb_sel_i[0] && adr_ok;
	wire logic [7:0] wbyte    = wb_dat_i[7:0];
	wire logic [7:0] soff     = idx - `RRC_IDX_STAGE_FIRST;
	wire logic       in_stage = (idx >= `RRC_IDX_STAGE_FIRST) &&
	                            (idx < (`RRC_IDX_STAGE_FIRST + 8'(`RRC_STAGE_BYTES)));

	wire logic wr_freeze  = wr && idx_is(idx, `RRC_IDX_FREEZE);
	wire logic wr_status  = wr && idx_is(idx, `RRC_IDX_STATUS);
	wire logic wr_base    = wr && idx_is(idx, `RRC_IDX_BASE_LO);
	wire logic wr_mult    = wr && idx_is(idx, `RRC_IDX_MULT_LO);
	wire logic wr_ratio   = wr && idx_is(idx, `RRC_IDX_RATIO_B0);
	wire logic any_commit = wr_base || wr_mult || wr_ratio;

	// freeze level follows only the two defined codes
	wire logic frozen_nxt = (wr_freeze && (wbyte == `RRC_FREEZE_ON))  ? 1'b1 :
	                        (wr_freeze && (wbyte == `RRC_FREEZE_OFF)) ? 1'b0 :
	                        frozen_r;

	// sticky status: events parked while frozen, merged on release; set beats clear
	wire logic [7:0] clr      = wr_status ? wbyte : 8'h00;
	wire logic [7:0] stat_nxt = frozen_r ? (stat_r & ~clr) : ((stat_r & ~clr) | pend_r | status_event_i);
	wire logic [7:0] pend_nxt = frozen_r ? (pend_r | status_event_i) : 8'h00;

	// whole values from staged higher bytes plus the byte written now
	wire logic [15:0] base_nxt  = wr_base ? {stage_r[0], wbyte} : base_r;
	wire logic [15:0] mult_nxt  = wr_mult ? {stage_r[2], wbyte} : mult_r;
	wire logic [31:0] ratio_nxt = wr_ratio ? {stage_r[4], stage_r[5], stage_r[6], wbyte} : ratio_r;

	// expected frequency numerator from the applied values
	wire rrc_freq_type prod = 48'(base_r) * 48'(mult_r) * 48'(ratio_r[`RRC_NUMER_MSB:`RRC_NUMER_LSB]);

	// read selection
	wire logic [7:0] stage_rd = in_stage ? stage_r[soff[2:0]] : 8'h00;
	wire logic [7:0] rd_byte  = !adr_ok                          ? 8'h00 :
	                            idx_is(idx, `RRC_IDX_FREEZE)     ? freeze_r :
	                            idx_is(idx, `RRC_IDX_STATUS)     ? stat_r :
	                            idx_is(idx, `RRC_IDX_CALC)       ? {6'h00, div_busy, div_valid} :
	                            stage_rd;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r  <= 1'b0;
			rdat_r <= '0;
		end
		else
		begin
			ack_r  <= req && !ack_r;
			rdat_r <= {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			freeze_r <= `RRC_FREEZE_RST;
			frozen_r <= 1'b0;
			stat_r   <= 8'h00;
			pend_r   <= 8'h00;
		end
		else
		begin
			if (wr_freeze)
			begin
				freeze_r <= wbyte;
			end
			frozen_r <= frozen_nxt;
			stat_r   <= stat_nxt;
			pend_r   <= pend_nxt;
		end
	end

	// byte staging, one flop byte per index
	genvar gi;
	generate
		for (gi = 0; gi < `RRC_STAGE_BYTES; gi++)
		begin : g_stage
			localparam logic [7:0] RST_BYTE = (gi < 2) ? 8'(`RRC_BASE_RST >> (8 * (1 - gi))) :
			                                  (gi < 4) ? 8'(`RRC_MULT_RST >> (8 * (3 - gi))) :
			                                  8'(`RRC_RATIO_RST >> (8 * (7 - gi)));
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					stage_r[gi] <= RST_BYTE;
				end
				else if (wr && in_stage && (soff[2:0] == 3'(gi)))
				begin
					stage_r[gi] <= wbyte;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			base_r  <= `RRC_BASE_RST;
			mult_r  <= `RRC_MULT_RST;
			ratio_r <= `RRC_RATIO_RST;
			start_r <= 1'b1;
		end
		else
		begin
			base_r  <= base_nxt;
			mult_r  <= mult_nxt;
			ratio_r <= ratio_nxt;
			start_r <= any_commit;
		end
	end

	rrc_div u_div (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.start_i    (start_r),
		.dividend_i (prod),
		.divisor_i  (ratio_r[`RRC_DENOM_MSB:`RRC_DENOM_LSB]),
		.busy_o     (div_busy),
		.valid_o    (div_valid),
		.quotient_o (div_quot)
	);

	assign wb_ack_o             = ack_r;
	assign wb_dat_o             = rdat_r;
	assign status_freeze_o      = frozen_r;
	assign frozen_read_status_o = stat_r;
	assign base_rate_hz_o       = base_r;
	assign rate_multiplier_o    = mult_r;
	assign fec_numerator_o      = ratio_r[`RRC_NUMER_MSB:`RRC_NUMER_LSB];
	assign fec_denominator_o    = ratio_r[`RRC_DENOM_MSB:`RRC_DENOM_LSB];
	assign expected_freq_o      = div_quot;
	assign expected_valid_o     = div_valid;
endmodule

// File: rrc_regs_chk.sv
// concurrent checks on the reference rate bank ports
module rrc_regs_chk
	import rrc_pkg::*;
(
	input wire logic         clk_i,
	input wire logic         rst_i,
	input wire logic         wb_cyc_i,
	input wire logic         wb_stb_i,
	input wire logic         wb_we_i,
	input wire logic [31:0]  wb_adr_i,
	input wire logic [3:0]   wb_sel_i,
	input wire logic [31:0]  wb_dat_i,
	input wire logic         wb_ack_o,
	input wire logic [31:0]  wb_dat_o,
	input wire logic [7:0]   status_event_i,
	input wire logic         status_freeze_o,
	input wire logic [7:0]   frozen_read_status_o,
	input wire logic [15:0]  base_rate_hz_o,
	input wire logic [15:0]  rate_multiplier_o,
	input wire logic [15:0]  fec_numerator_o,
	input wire logic [15:0]  fec_denominator_o,
	input wire rrc_freq_type expected_freq_o,
	input wire logic         expected_valid_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// committed write and its word index, unmapped forms map to 0xFF
	wire       wr_w = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	wire [7:0] ix_w = (wb_adr_i[31:10] == 22'h0 && wb_adr_i[1:0] == 2'h0) ? wb_adr_i[9:2] : 8'hFF;
	wire [7:0] d_w  = wb_dat_i[7:0];
	AST_ACK_ONCE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
	AST_FRZ_ON: assert property (wr_w && ix_w == 8'h0D && d_w == 8'h01 |=> status_freeze_o)
		else $error("freeze not set");
	AST_FRZ_OFF: assert property (wr_w && ix_w == 8'h0D && d_w == 8'h00 |=> !status_freeze_o)
		else $error("freeze not cleared");
	AST_FRZ_HOLD: assert property (status_freeze_o && !(wr_w && ix_w == 8'h0E) |=> $stable(frozen_read_status_o))
		else $error("status moved while frozen");
	AST_LIVE: assert property (!status_freeze_o && !(wr_w && ix_w == 8'h0D)
		|=> (frozen_read_status_o & $past(status_event_i)) == $past(status_event_i))
		else $error("status event lost");
	AST_BASE_LO: assert property (wr_w && ix_w == 8'h11 |=> base_rate_hz_o[7:0] == $past(d_w))
		else $error("base rate not applied");
	AST_MULT_LO: assert property (wr_w && ix_w == 8'h13 |=> rate_multiplier_o[7:0] == $past(d_w))
		else $error("multiplier not applied");
	AST_DEN_LO: assert property (wr_w && ix_w == 8'h17 |=> fec_denominator_o[7:0] == $past(d_w))
		else $error("denominator not applied");
	AST_WHOLE: assert property (!(wr_w && (ix_w == 8'h11 || ix_w == 8'h13 || ix_w == 8'h17))
		|=> $stable({base_rate_hz_o, rate_multiplier_o, fec_numerator_o, fec_denominator_o}))
		else $error("value applied piecewise");
	AST_FREQ: assert property ($rose(expected_valid_o) && fec_denominator_o != 16'h0
		|-> expected_freq_o == 48'(base_rate_hz_o) * rate_multiplier_o * fec_numerator_o / fec_denominator_o)
		else $error("expected frequency wrong");
	cover property (wr_w && ix_w == 8'h17);
	cover property ($rose(status_freeze_o));
	cover property ($rose(expected_valid_o));
endmodule

// File: rrc_host.sv
// wishbone host model that programs the reference rate bank
module rrc_host
(
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [31:0]      adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// byte enables for the next transfer, set by the bench
	logic [3:0] sel_r = 4'hF;
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		sel_o = 4'hF;
		we_o = 1'b0;
		adr_o = 32'h0;
		dat_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		sel_o <= sel_r;
		we_o <= w;
		adr_o <= {22'h0, i, 2'h0};
		dat_o <= {24'h0, d};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// released lines show no stale value
		adr_o <= ~adr_o;
		dat_o <= ~dat_o;
	endtask
	// high byte to the lower address
	task automatic wr16(input logic [7:0] i, input logic [15:0] v);
		xfer(1'b1, i, v[15:8]);
		xfer(1'b1, i + 8'h01, v[7:0]);
	endtask
endmodule

// File: rrc_tb.sv
// self-checking bench of the reference rate bank
bind rrc_regs rrc_regs_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_ack_o, .wb_dat_o, .status_event_i, .status_freeze_o, .frozen_read_status_o, .base_rate_hz_o,
	.rate_multiplier_o, .fec_numerator_o, .fec_denominator_o, .expected_freq_o, .expected_valid_o);
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] BR [9] = '{16'h03E8, 16'h07D0, 16'h1388, 16'h186A, 16'h1F40,
		16'h2710, 16'h30D4, 16'h61A8, 16'h9C40};
	localparam logic [7:0]  RST [8] = '{8'h9C, 8'h40, 8'h0F, 8'h30, 8'h00, 8'h01, 8'h00, 8'h01};
	localparam logic [15:0] MR [3] = '{16'h00FF, 16'h41BE, 16'h0001};
	localparam logic [15:0] NR [3] = '{16'h00ED, 16'h3B80, 16'h0001};
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  status_event_i = 8'h00;
	logic        vld_r = 1'b0;
	logic [7:0]  e;
	logic [15:0] b;
	logic [15:0] k;
	logic [31:0] rq[$];
	logic [47:0] fq[$];
	int          err_count = 0;
	int          checks_done = 0;
	int          cyc_n = 0;
	wire         wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, status_freeze_o, expected_valid_o;
	wire  [3:0]  wb_sel_i;
	wire  [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
	wire  [7:0]  frozen_read_status_o;
	wire  [15:0] base_rate_hz_o, rate_multiplier_o, fec_numerator_o, fec_denominator_o;
	wire  [47:0] expected_freq_o;
	always #5 clk_i = ~clk_i;
	rrc_regs dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_ack_o, .wb_dat_o, .status_event_i, .status_freeze_o, .frozen_read_status_o, .base_rate_hz_o,
		.rate_multiplier_o, .fec_numerator_o, .fec_denominator_o, .expected_freq_o, .expected_valid_o);
	rrc_host host_u (.clk_i, .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
		.adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] x);
		rq.push_back({24'h0, x});
		host_u.xfer(1'b0, i, 8'h00);
	endtask
	task wait_fq;
		while (fq.size() > 0)
			@(posedge clk_i);
	endtask
	// result watcher and hang limit
	always @(posedge clk_i)
	begin
		vld_r <= expected_valid_o;
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			check(wb_dat_o, rq.pop_front());
		if (expected_valid_o === 1'b1 && vld_r !== 1'b1)
			check(expected_freq_o, fq.pop_front());
		cyc_n++;
		if (cyc_n > 5000)
		begin
			err_count++;
			summarize();
		end
	end
	initial
	begin
		void'($urandom(32'h804e2f7b));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		fq.push_back(48'd155520000);
		foreach (RST[i])
			rd(8'h10 + 8'(i), RST[i]);
		check({base_rate_hz_o, rate_multiplier_o}, {16'h9C40, 16'h0F30});
		check({fec_numerator_o, fec_denominator_o}, 32'h00010001);
		host_u.xfer(1'b1, 8'hFC, 8'h5A);
		rd(8'hFC, 8'h00);
		// write without the low byte enable must be ignored
		host_u.sel_r = 4'hE;
		host_u.xfer(1'b1, 8'h0D, 8'h01);
		host_u.sel_r = 4'hF;
		rd(8'h0D, 8'h00);
		host_u.xfer(1'b1, 8'h0D, 8'h01);
		e = 8'($urandom) | 8'h01;
		@(posedge clk_i);
		status_event_i <= e;
		@(posedge clk_i);
		status_event_i <= 8'h00;
		rd(8'h0E, 8'h00);
		rd(8'h0D, 8'h01);
		host_u.xfer(1'b1, 8'h0D, 8'h00);
		rd(8'h0E, e);
		host_u.xfer(1'b1, 8'h0E, e);
		rd(8'h0E, 8'h00);
		for (int n = 0; n < 3; n++)
		begin
			wait_fq();
			b = BR[$urandom_range(8)];
			k = 16'($urandom);
			host_u.wr16(8'h10, b);
			host_u.wr16(8'h12, k);
			host_u.wr16(8'h14, MR[n]);
			host_u.wr16(8'h16, NR[n]);
			fq.push_back(48'(b) * 48'(k) * 48'(MR[n]) / 48'(NR[n]));
			rd(8'h14, MR[n][15:8]);
			rd(8'h17, NR[n][7:0]);
			check({base_rate_hz_o, rate_multiplier_o}, {b, k});
			check({fec_numerator_o, fec_denominator_o}, {MR[n], NR[n]});
		end
		wait_fq();
		// halved input: 311.04 MHz programmed as half its rate
		host_u.wr16(8'h10, 16'h9C40);
		host_u.wr16(8'h12, 16'h1E60 >> 1);
		fq.push_back(48'd155520000);
		wait_fq();
		summarize();
	end
endmodule
